// ---- design/tbid_pkg.sv ----
// package: encodings, field positions, reset values and timing for the instruction decoder
package tbid_pkg;
	localparam int OSC_PER_CYCLE = 4;
	localparam int OSC_PERIOD_NS = 8;
	localparam int CYCLE_NS = OSC_PER_CYCLE * OSC_PERIOD_NS;
	localparam int CYCLE_CLKS = (CYCLE_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS;
	localparam logic [1:0] PHASE_LAST = 2'(CYCLE_CLKS - 1);
	localparam logic [4:0] ADDR_TIMER = 5'h01;
	localparam logic [4:0] ADDR_PCL = 5'h02;
	localparam logic [4:0] ADDR_STATUS = 5'h03;
	localparam logic [4:0] ADDR_PORT = 5'h06;
	localparam logic [2:0] PORT_DIRECTION_LOAD_PORT_SEL = 3'h6;
	localparam int ST_C = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z = 2;
	localparam int ST_PD = 3;
	localparam int ST_TO = 4;
	localparam int OPT_PSA = 3;
	localparam logic [7:0] RST_ACCUM = 8'h00;
	localparam logic [7:0] RST_OPTION = 8'hFF;
	localparam logic [7:0] RST_PORT_DIRECTION_LOAD = 8'hFF;
	localparam logic [7:0] RST_STATUS = 8'h18;
	localparam logic [8:0] RST_PC = 9'h1FF;
	localparam logic [11:0] INSN_NOP = 12'h000;
	localparam logic [11:0] INSN_OPTION = 12'h002;
	localparam logic [11:0] INSN_SLEEP = 12'h003;
	localparam logic [11:0] INSN_WDT = 12'h004;
	localparam logic [11:0] INSN_ZACC = 12'h040;
	localparam logic [3:0] OP_BCF = 4'h4;
	localparam logic [3:0] OP_BSF = 4'h5;
	localparam logic [3:0] OP_SKC = 4'h6;
	localparam logic [3:0] OP_SKS = 4'h7;
	localparam logic [3:0] OP_RET = 4'h8;
	localparam logic [3:0] OP_CALL = 4'h9;
	localparam logic [3:0] OP_MOVL = 4'hC;
	localparam logic [3:0] OP_IORL = 4'hD;
	localparam logic [3:0] OP_ANDL = 4'hE;
	localparam logic [3:0] OP_XORL = 4'hF;
	// file write request to the data memory and special registers
	typedef struct packed {
		logic en;
		logic [4:0] addr;
		logic [7:0] data;
	} tbid_fwrite_type;
	// side effects toward timer, watchdog and standby logic
	typedef struct packed {
		logic sleep;
		logic wdt_clear;
		logic prescaler_clear;
	} tbid_side_type;
endpackage

// ---- design/tbid_stack.sv ----
// two-level return address stack with registered top
`timescale 1ns/1ps
module tbid_stack #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 2
) (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic push_i,
	input wire logic pop_i,
	input wire logic [WIDTH-1:0] push_data_i,
	output logic [WIDTH-1:0] top_o
);
	logic [WIDTH-1:0] level [DEPTH];
	// push shifts down, pop shifts up; the bottom entry repeats on pop
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				level[i] <= '0;
			end
		end else if (push_i) begin
			level[0] <= push_data_i;
			for (int i = 1; i < DEPTH; i++) begin
				level[i] <= level[i-1];
			end
		end else if (pop_i) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				level[i] <= level[i+1];
			end
		end
	end
	assign top_o = level[0];
endmodule

// ---- design/tbid_core.sv ----
// instruction decoder and executor for the twelve-bit word core
// Function
// - add sets carry, nibble-overflow and zero
// - destination bit picks accumulator or file
// - or, and, xor with file set zero
// - decrement/increment skip on zero, no flags
// - rotate through carry, only carry changes
// - bit test skips on clear or set
// - literal or, and, xor set zero
// - pc writes clear bit eight except jump and return
// - return loads literal, pops, two cycles
// - sleep enters standby, updates status flags
// - accumulator loads timing configuration register
// - direction load for port six, one floats
// - port read-modify-write uses pin levels
// - timer writes clear assigned prescaler
// - four clocks per cycle, branches two
`timescale 1ns/1ps
module tbid_core #(
	parameter int STACK_DEPTH = 2
) (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic [11:0] insn_i,
	input wire logic [7:0] file_rdata_i,
	input wire logic [7:0] port_pins_i,
	output logic [8:0] pc_o,
	output logic [4:0] file_raddr_o,
	output tbid_pkg::tbid_fwrite_type fwrite_o,
	output logic [7:0] accum_o,
	output logic [7:0] status_o,
	output logic [7:0] option_o,
	output logic [7:0] port_port_direction_load_o,
	output tbid_pkg::tbid_side_type side_o,
	output logic sleeping_o
);
	// ****************************************
	// state and decode
	// ****************************************
	typedef enum {EXEC, FLUSH, HALT} tbid_state_type;
	tbid_state_type state;
	logic [1:0] phase;
	logic [7:0] pins_s1, pins_s2, pins_s3;
	logic [7:0] pins;
	logic [8:0] pc;
	logic [8:0] stack_top;
	logic [7:0] accum, status;
	logic [3:0] op;
	logic [4:0] faddr;
	logic dest;
	logic [2:0] bsel;
	logic [7:0] lit;
	logic [7:0] src;
	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] res;
	logic wr_res, set_c, set_dc, set_z, skip, push, pop, jump;
	logic new_c, new_dc;
	logic [8:0] target;
	logic wdt_op, sleep_op, opt_op, port_direction_load_op;
	logic exec_edge;

	assign op = insn_i[11:8];
	assign faddr = insn_i[4:0];
	assign dest = insn_i[5];
	assign bsel = insn_i[7:5];
	assign lit = insn_i[7:0];
	assign exec_edge = (phase == tbid_pkg::PHASE_LAST) && (state == EXEC);

	// pin levels through three flops; a change counts when stages two and three agree
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pins_s1 <= 8'h00;
			pins_s2 <= 8'h00;
			pins_s3 <= 8'h00;
			pins <= 8'h00;
		end else begin
			pins_s1 <= port_pins_i;
			pins_s2 <= pins_s1;
			pins_s3 <= pins_s2;
			if (pins_s2 == pins_s3) begin
				pins <= pins_s3;
			end
		end
	end

	// port operand comes from sampled pins, not the latch
	always_comb begin
		src = (faddr == tbid_pkg::ADDR_PORT) ? pins : file_rdata_i;
	end

	// ****************************************
	// execute
	// ****************************************
	// combinational result, flags and control flow for the current word
	always_comb begin
		sum = {1'b0, accum} + {1'b0, src};
		nib = {1'b0, accum[3:0]} + {1'b0, src[3:0]};
		res = src;
		wr_res = 1'b0;
		set_c = 1'b0;
		set_dc = 1'b0;
		set_z = 1'b0;
		new_c = status[tbid_pkg::ST_C];
		new_dc = status[tbid_pkg::ST_DC];
		skip = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		jump = 1'b0;
		target = 9'h000;
		wdt_op = 1'b0;
		sleep_op = 1'b0;
		opt_op = 1'b0;
		port_direction_load_op = 1'b0;
		case (insn_i[11:6])
			6'h00: begin
				case (insn_i[5:0])
					6'h00: ; // no operation
					6'h02: opt_op = 1'b1;
					6'h03: sleep_op = 1'b1;
					6'h04: wdt_op = 1'b1;
					default: port_direction_load_op = (insn_i[5:3] == 3'h0);
				endcase
				if (insn_i[5]) begin
					wr_res = 1'b1; // store accumulator to file
					res = accum;
				end
			end
			6'h01: begin
				res = 8'h00; // zero file or zero accumulator
				wr_res = 1'b1;
				set_z = 1'b1;
			end
			6'h02: begin
				sum = {1'b0, src} - {1'b0, accum}; // subtract, carry is not-borrow
				nib = {1'b0, src[3:0]} - {1'b0, accum[3:0]};
				res = sum[7:0];
				new_c = ~sum[8];
				new_dc = ~nib[4];
				{set_c, set_dc, set_z, wr_res} = 4'hF;
			end
			6'h03: begin
				res = src - 8'h01;
				{set_z, wr_res} = 2'h3;
			end
			6'h04, 6'h05, 6'h06: begin
				case (insn_i[7:6])
					2'h0: res = accum | src;
					2'h1: res = accum & src;
					default: res = accum ^ src;
				endcase
				{set_z, wr_res} = 2'h3;
			end
			6'h07: begin
				res = sum[7:0]; // add
				new_c = sum[8];
				new_dc = nib[4];
				{set_c, set_dc, set_z, wr_res} = 4'hF;
			end
			6'h08: {set_z, wr_res} = 2'h3; // move file
			6'h09: begin
				res = ~src;
				{set_z, wr_res} = 2'h3;
			end
			6'h0A: begin
				res = src + 8'h01;
				{set_z, wr_res} = 2'h3;
			end
			6'h0B, 6'h0F: begin
				res = insn_i[8] ? src + 8'h01 : src - 8'h01; // no flags
				wr_res = 1'b1;
				skip = (res == 8'h00);
			end
			6'h0C: begin
				res = {status[tbid_pkg::ST_C], src[7:1]};
				new_c = src[0];
				{set_c, wr_res} = 2'h3;
			end
			6'h0D: begin
				res = {src[6:0], status[tbid_pkg::ST_C]};
				new_c = src[7];
				{set_c, wr_res} = 2'h3;
			end
			6'h0E: begin
				res = {src[3:0], src[7:4]};
				wr_res = 1'b1;
			end
			default: begin
				case (op)
					tbid_pkg::OP_BCF, tbid_pkg::OP_BSF: begin
						res = src;
						res[bsel] = op[0];
						wr_res = 1'b1;
					end
					tbid_pkg::OP_SKC: skip = ~src[bsel];
					tbid_pkg::OP_SKS: skip = src[bsel];
					tbid_pkg::OP_RET: begin
						pop = 1'b1;
						jump = 1'b1;
						target = stack_top;
					end
					tbid_pkg::OP_CALL: begin
						push = 1'b1;
						jump = 1'b1;
						target = {1'b0, lit};
					end
					tbid_pkg::OP_MOVL: ;
					tbid_pkg::OP_IORL: set_z = 1'b1;
					tbid_pkg::OP_ANDL: set_z = 1'b1;
					tbid_pkg::OP_XORL: set_z = 1'b1;
					default: begin
						jump = 1'b1; // jump keeps all nine bits
						target = insn_i[8:0];
					end
				endcase
			end
		endcase
	end

	// ****************************************
	// sequencing
	// ****************************************
	// four clocks per instruction cycle
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			phase <= 2'h0;
		end else if (phase == tbid_pkg::PHASE_LAST) begin
			phase <= 2'h0;
		end else begin
			phase <= phase + 2'h1;
		end
	end

	// branches and true skips spend a second cycle flushing
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state <= EXEC;
		end else if (phase == tbid_pkg::PHASE_LAST) begin
			case (state)
				EXEC: begin
					if (sleep_op) begin
						state <= HALT;
					end else if (jump || skip || (wr_res && dest && faddr == tbid_pkg::ADDR_PCL)) begin
						state <= FLUSH;
					end
				end
				FLUSH: state <= EXEC;
				HALT: state <= HALT;
				default: state <= EXEC;
			endcase
		end
	end

	// program counter; writes to its low byte clear bit eight
	// the flush cycle holds pc so a loaded target is the next word executed
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pc <= tbid_pkg::RST_PC;
		end else if (exec_edge) begin
			if (jump) begin
				pc <= target;
			end else if (wr_res && dest && faddr == tbid_pkg::ADDR_PCL) begin
				pc <= {1'b0, res};
			end else if (skip) begin
				pc <= pc + 9'h002; // step over the skipped word
			end else begin
				pc <= pc + 9'h001;
			end
		end
	end

	tbid_stack #(
		.WIDTH(9),
		.DEPTH(STACK_DEPTH)
	) u_stack (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.push_i(exec_edge && push),
		.pop_i(exec_edge && pop),
		.push_data_i(pc + 9'h001),
		.top_o(stack_top)
	);

	// accumulator: byte results with dest zero and literal ops
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			accum <= tbid_pkg::RST_ACCUM;
		end else if (exec_edge) begin
			case (op)
				tbid_pkg::OP_RET, tbid_pkg::OP_MOVL: accum <= lit;
				tbid_pkg::OP_IORL: accum <= accum | lit;
				tbid_pkg::OP_ANDL: accum <= accum & lit;
				tbid_pkg::OP_XORL: accum <= accum ^ lit;
				default: begin
					if (insn_i[11:10] == 2'h0 && wr_res && !dest && insn_i[11:6] != 6'h00) begin
						accum <= res;
					end
				end
			endcase
		end
	end

	// status flags: arithmetic flags and the time-out / power-down pair
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			status <= tbid_pkg::RST_STATUS;
		end else if (exec_edge) begin
			if (set_c) begin
				status[tbid_pkg::ST_C] <= new_c;
			end
			if (set_dc) begin
				status[tbid_pkg::ST_DC] <= new_dc;
			end
			if (set_z) begin
				status[tbid_pkg::ST_Z] <= (op[3:2] == 2'h3) ? (((op == tbid_pkg::OP_IORL) ?
					accum | lit : (op == tbid_pkg::OP_ANDL) ? accum & lit : accum ^ lit)
					== 8'h00) : (res == 8'h00);
			end
			if (sleep_op) begin
				status[tbid_pkg::ST_TO] <= 1'b1;
				status[tbid_pkg::ST_PD] <= 1'b0;
			end
			if (wdt_op) begin
				status[tbid_pkg::ST_TO] <= 1'b1;
				status[tbid_pkg::ST_PD] <= 1'b1;
			end
		end
	end

	// timing configuration and port direction loads
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			option_o <= tbid_pkg::RST_OPTION;
			port_port_direction_load_o <= tbid_pkg::RST_PORT_DIRECTION_LOAD;
		end else if (exec_edge) begin
			if (opt_op) begin
				option_o <= accum;
			end
			if (port_direction_load_op && insn_i[2:0] == tbid_pkg::PORT_DIRECTION_LOAD_PORT_SEL) begin
				port_port_direction_load_o <= accum; // one floats the pin
			end
		end
	end

	// file writes and side-effect strobes, one clock at the cycle end
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			fwrite_o <= '0;
			side_o <= '0;
		end else begin
			fwrite_o.en <= exec_edge && wr_res && (dest || op[3:1] == 3'h2); // zero accum stays off the file
			fwrite_o.addr <= faddr;
			fwrite_o.data <= res;
			side_o.sleep <= exec_edge && sleep_op;
			side_o.wdt_clear <= exec_edge && (wdt_op || sleep_op);
			side_o.prescaler_clear <= exec_edge && wr_res && faddr == tbid_pkg::ADDR_TIMER
				&& (dest || op[3:1] == 3'h2)
				&& !option_o[tbid_pkg::OPT_PSA];
		end
	end

	// registered copies of core state for the outside
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pc_o <= tbid_pkg::RST_PC;
			file_raddr_o <= 5'h00;
			accum_o <= tbid_pkg::RST_ACCUM;
			status_o <= tbid_pkg::RST_STATUS;
			sleeping_o <= 1'b0;
		end else begin
			pc_o <= pc;
			file_raddr_o <= faddr;
			accum_o <= accum;
			status_o <= status;
			sleeping_o <= (state == HALT);
		end
	end
endmodule

// ---- bench/tbid_assertions.sv ----
// checker: port-level timing relations of the instruction decoder
`timescale 1ns/1ps
module tbid_assertions (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic [8:0] pc_o,
	input wire tbid_pkg::tbid_fwrite_type fwrite_o,
	input wire logic [7:0] accum_o,
	input wire logic [7:0] status_o,
	input wire logic [7:0] option_o,
	input wire logic [7:0] port_port_direction_load_o,
	input wire tbid_pkg::tbid_side_type side_o,
	input wire logic sleeping_o
);
	// ********
	// properties
	// ********
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (reset_i);
	// three idle clocks after a write
	sequence s_quiet;
		!fwrite_o.en [*3];
	endsequence
	// standby seen on two edges
	sequence s_halt;
		sleeping_o ##1 sleeping_o;
	endsequence
	a_write_gap: assert property (fwrite_o.en |=> s_quiet)
		else $error("file writes closer than one cycle");
	a_pc_step: assert property ($changed(pc_o) |=> $stable(pc_o) [*3])
		else $error("pc moved inside a cycle");
	a_sleep_sticky: assert property (sleeping_o |=> sleeping_o)
		else $error("standby left without reset");
	a_halt_quiet: assert property (s_halt |-> !fwrite_o.en && $stable(accum_o))
		else $error("work done in standby");
	a_sleep_flags: assert property (side_o.sleep |-> ##[0:3] (sleeping_o && status_o[4:3] == 2'b10))
		else $error("standby flags wrong");
	a_kick_flags: assert property (side_o.wdt_clear && !side_o.sleep |-> ##[0:3] status_o[4:3] == 2'b11)
		else $error("watchdog kick flags wrong");
	a_timer_clear: assert property (fwrite_o.en |-> side_o.prescaler_clear ==
		(fwrite_o.addr == tbid_pkg::ADDR_TIMER && !option_o[tbid_pkg::OPT_PSA]))
		else $error("prescaler clear mismatch");
	a_clear_cause: assert property (side_o.prescaler_clear |-> fwrite_o.en)
		else $error("prescaler clear without write");
	a_port_direction_load_acc: assert property ($changed(port_port_direction_load_o) |-> port_port_direction_load_o == accum_o)
		else $error("direction not from accumulator");
	a_option_acc: assert property ($changed(option_o) |-> option_o == accum_o)
		else $error("option not from accumulator");
endmodule
bind tbid_core tbid_assertions u_chk (
	.ref_clk_i(ref_clk_i),
	.reset_i(reset_i),
	.pc_o(pc_o),
	.fwrite_o(fwrite_o),
	.accum_o(accum_o),
	.status_o(status_o),
	.option_o(option_o),
	.port_port_direction_load_o(port_port_direction_load_o),
	.side_o(side_o),
	.sleeping_o(sleeping_o)
);

// ---- bench/tbid_prog_mem.sv ----
// program memory model that feeds instruction words
`timescale 1ns/1ps
module tbid_prog_mem (
	input wire logic [8:0] addr_i,
	output logic [11:0] word_o
);
	logic [11:0] mem [512];
	// word follows the program counter
	assign word_o = mem[addr_i];
endmodule

// ---- bench/tbid_test.sv ----
// self-checking bench for the instruction decoder core
`timescale 1ns/1ps
module tbid_test;
	logic ref_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [7:0] file_rdata_i = 8'h00;
	logic [7:0] port_pins_i = 8'h00;
	logic [11:0] insn_i, w;
	logic [8:0] pc_o;
	tbid_pkg::tbid_fwrite_type fwrite_o, wr;
	tbid_pkg::tbid_side_type side_o, sd;
	logic [7:0] accum_o, status_o, option_o, port_port_direction_load_o, a, f;
	logic [10:0] e;
	logic [2:0] b;
	logic sleeping_o, d;
	int op, n_fail = 0, tests_run = 0;
	logic [31:0] seed = 32'h850F3D98;
	logic [11:0] prog [$];
	logic [11:0] ops [7] = '{12'h1D0, 12'h110, 12'h150, 12'h190, 12'hD00, 12'hE00, 12'hF00};
	logic [11:0] sk_w [4] = '{12'h2D0, 12'h3D0, 12'h610, 12'h710};
	logic [7:0] sk_f [4] = '{8'h01, 8'hFF, 8'h00, 8'hFF};
	logic [11:0] xops [9] = '{12'h350, 12'h310, 12'h390, 12'h250, 12'h290, 12'h0D0, 12'h090,
		12'h510, 12'h410};
	logic [8:0] g;
	always #4 ref_clk_i = ~ref_clk_i;
	tbid_prog_mem tb_mem (.addr_i(pc_o), .word_o(insn_i));
	tbid_core DUT (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.insn_i(insn_i),
		.file_rdata_i(file_rdata_i),
		.port_pins_i(port_pins_i),
		.pc_o(pc_o),
		.file_raddr_o(),
		.fwrite_o(fwrite_o),
		.accum_o(accum_o),
		.status_o(status_o),
		.option_o(option_o),
		.port_port_direction_load_o(port_port_direction_load_o),
		.side_o(side_o),
		.sleeping_o(sleeping_o)
	);
	// ********
	// helpers
	// ********
	// latch last file write and any side pulse
	always @(posedge ref_clk_i) begin
		if (fwrite_o.en === 1'b1) wr <= fwrite_o;
		sd <= sd | side_o;
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// expected {z, dc, c, result}
	function automatic logic [10:0] alu(int o, logic [7:0] x, logic [7:0] y);
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] r;
		s = x + y;
		h = x[3:0] + y[3:0];
		case (o)
			0: r = s[7:0];
			1, 4: r = x | y;
			2, 5: r = x & y;
			default: r = x ^ y;
		endcase
		if (o != 0) begin
			s[8] = 1'b0;
			h[4] = 1'b0;
		end
		return {r == 8'h00, h[4], s[8], r};
	endfunction
	function automatic logic skip(int o, logic [7:0] y, logic [2:0] n);
		case (o)
			0: return y == 8'h01;
			1: return y == 8'hFF;
			2: return !y[n];
			default: return y[n];
		endcase
	endfunction
	// expected {carry, result} of rotate, swap, invert, step, subtract and bit ops
	function automatic logic [8:0] xexp(int o, logic [7:0] x, logic [7:0] y, logic [2:0] n);
		logic [7:0] r;
		r = y;
		case (o)
			0: return {y[7], y[6:0], 1'b0};
			1: return {y[0], 1'b0, y[7:1]};
			2: return {1'b0, y[3:0], y[7:4]};
			3: return {1'b0, ~y};
			4: return {1'b0, 8'(y + 8'h01)};
			5: return {1'b0, 8'(y - 8'h01)};
			6: return {y >= x, 8'(y - x)};
			7: begin
				r[n] = 1'b1;
				return {1'b0, r};
			end
			default: begin
				r[n] = 1'b0;
				return {1'b0, r};
			end
		endcase
	endfunction
	task automatic check(string what, logic [7:0] exp, logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// reset, load program from the reset vector, run n cycles
	task automatic run(int n);
		@(negedge ref_clk_i);
		reset_i = 1'b1;
		wr = '0;
		sd = '0;
		foreach (prog[i]) tb_mem.mem[9'(9'h1FF + i)] = prog[i];
		repeat (2) @(negedge ref_clk_i);
		reset_i = 1'b0;
		repeat (4 * n + 3) @(negedge ref_clk_i);
	endtask
	task automatic final_report();
		$display("checks %0d failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ********
	// tests
	// ********
	initial begin
		#100000;
		n_fail++;
		final_report();
	end
	initial begin
		repeat (6) @(negedge ref_clk_i);
		reset_i = 1'b0;
		// file and literal arithmetic, first pass hits all flags
		for (int i = 0; i < 14; i++) begin
			op = i % 7;
			a = (i == 0) ? 8'hFF : 8'(rnd());
			f = (i == 0) ? 8'h01 : 8'(rnd());
			d = op < 4 && seed[7];
			w = op < 4 ? ops[op] | {6'h0, d, 5'h00} : ops[op] | {4'h0, f};
			file_rdata_i = f;
			prog = '{12'hC00 | {4'h0, a}, w};
			run(2);
			e = alu(op, a, f);
			check("status", {3'b000, 2'b11, e[10:8]}, status_o);
			if (d) begin
				check("fdata", e[7:0], wr.data);
				check("keep", a, accum_o);
			end else begin
				check("accum", e[7:0], accum_o);
			end
		end
		$display("done alu");
		// conditional skips
		for (int i = 0; i < 8; i++) begin
			op = i % 4;
			f = i < 4 ? sk_f[op] : 8'(rnd());
			b = 3'(rnd());
			w = op > 1 ? sk_w[op] | {4'h0, b, 5'h00} : sk_w[op];
			file_rdata_i = f;
			prog = '{w, 12'hC55, 12'hDAA};
			run(3);
			check("skip", skip(op, f, b) ? 8'hAA : 8'hFF, accum_o);
			check("sflags", 8'h18, status_o);
		end
		$display("done skip");
		// remaining byte and bit operations on a file operand
		for (int i = 0; i < 9; i++) begin
			a = 8'(rnd());
			f = 8'(rnd());
			b = 3'(rnd());
			file_rdata_i = f;
			w = i > 6 ? xops[i] | {4'h0, b, 5'h00} : xops[i];
			prog = '{12'hC00 | {4'h0, a}, w};
			run(2);
			g = xexp(i, a, f, b);
			check("xres", g[7:0], i < 7 ? accum_o : wr.data);
			check("xcarry", {7'h0, g[8]}, {7'h0, status_o[0]});
		end
		$display("done byte");
		// jump, call, return
		tb_mem.mem[9'h108] = 12'hC3C;
		tb_mem.mem[9'h008] = 12'hCC3;
		prog = '{12'hB08, 12'hC11};
		run(3);
		check("jump", 8'h3C, accum_o);
		tb_mem.mem[9'h006] = 12'hC77;
		tb_mem.mem[9'h106] = 12'hC99;
		tb_mem.mem[9'h007] = 12'h8A5;
		prog = '{12'h906, 12'hC11};
		run(3);
		check("call", 8'h77, accum_o);
		repeat (8) @(negedge ref_clk_i);
		check("ret", 8'hA5, accum_o);
		repeat (4) @(negedge ref_clk_i);
		check("back", 8'h11, accum_o);
		$display("done flow");
		// option, direction, timer write
		a = 8'(rnd()) & 8'hF7;
		prog = '{12'hC00 | {4'h0, a}, tbid_pkg::INSN_OPTION, 12'h006, 12'h021};
		run(4);
		check("option", a, option_o);
		check("port_direction_load", a, port_port_direction_load_o);
		check("timer", a, wr.data);
		check("pclr", 8'h01, {7'h0, sd.prescaler_clear});
		// port read uses the pins
		port_pins_i = 8'(rnd());
		file_rdata_i = ~port_pins_i;
		prog = '{tbid_pkg::INSN_NOP, 12'h206};
		run(2);
		check("pins", port_pins_i, accum_o);
		// watchdog kick then standby
		prog = '{tbid_pkg::INSN_WDT, tbid_pkg::INSN_SLEEP, 12'hC5A};
		run(3);
		check("kick", 8'h01, {7'h0, sd.wdt_clear});
		check("sleep", 8'h01, {7'h0, sleeping_o});
		check("flags", 8'h10, status_o & 8'h18);
		check("frozen", 8'h00, accum_o);
		$display("done control");
		final_report();
	end
endmodule
